// ==== rtl/ufa_top.sv ====
// Serial port with framing error check and automatic address recognition.
// Assumes an AHB-Lite master on hclk and an asynchronous rxd pin.
module ufa_top
   import ufa_pkg::*;
#(
   parameter logic [15:0] DIV_DEFAULT = DIV_RST
)(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        rxd,
   output logic             txd,
   output logic             irq
);
   // ***************************************************************
   // Bus slave
   // ***************************************************************
   ufa_aphase_t ap_q;
   logic        wr_q, rd_q, rdy_q;
   logic [31:0] rdata_q;
   logic        take;
   assign take = hsel & htrans[1] & hready;
   // Reads take one wait state because the read data is registered.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_q <= '0;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         rdy_q <= 1'b1;
      end else begin
         if (take) begin
            ap_q <= '{wr: hwrite, ofs: haddr[7:0]};
         end
         wr_q <= take & hwrite;
         rd_q <= take & ~hwrite;
         rdy_q <= ~(take & ~hwrite);
      end
   end
   logic w_serial_control_reg, w_power_control_reg, w_sadr, w_sadn, w_sbuf, w_rxdv, w_txdv;
   logic w_ist, w_imk;
   assign w_serial_control_reg = wr_q & (ap_q.ofs == OFS_SERIAL_CONTROL_REG);
   assign w_power_control_reg = wr_q & (ap_q.ofs == OFS_POWER_CONTROL_REG);
   assign w_sadr = wr_q & (ap_q.ofs == OFS_OWN_ADDRESS_REG);
   assign w_sadn = wr_q & (ap_q.ofs == OFS_ADDRESS_MASK_REG);
   assign w_sbuf = wr_q & (ap_q.ofs == OFS_SBUF);
   assign w_rxdv = wr_q & (ap_q.ofs == OFS_RXDIV);
   assign w_txdv = wr_q & (ap_q.ofs == OFS_TXDIV);
   assign w_ist  = wr_q & (ap_q.ofs == OFS_IRQST);
   assign w_imk  = wr_q & (ap_q.ofs == OFS_IRQMSK);
   // ***************************************************************
   // Control registers
   // ***************************************************************
   ufa_ctl_t   ctl_q;
   logic       fce_q, fe_q, ri_q, ti_q, rb8_q;
   logic [7:0] own_address_reg_q, address_mask_reg_q, rbuf_q;
   logic [15:0] rxdiv_q, txdiv_q;
   logic [IRQ_W-1:0] ist_q, imk_q;
   logic [1:0] mode;
   logic       chk, mp_on;
   assign mode  = {ctl_q.sm0, ctl_q.sm1};
   assign chk   = fce_q & (mode != MODE0);
   assign mp_on = ctl_q.sm2 & (mode != MODE0);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctl_q   <= '0;
         fce_q   <= 1'b0;
         own_address_reg_q <= ADDR_RST;
         address_mask_reg_q <= MASK_RST;
         rxdiv_q <= DIV_DEFAULT;
         txdiv_q <= DIV_DEFAULT;
         imk_q   <= '0;
      end else begin
         if (w_serial_control_reg) begin
            ctl_q.sm1 <= hwdata[SC_SM1];
            ctl_q.sm2 <= hwdata[SC_SM2];
            ctl_q.ren <= hwdata[SC_REN];
            ctl_q.tb8 <= hwdata[SC_TB8];
            if (!fce_q) ctl_q.sm0 <= hwdata[SC_FE];
         end
         if (w_power_control_reg) fce_q <= hwdata[PC_FCE];
         if (w_sadr) own_address_reg_q <= hwdata[7:0];
         if (w_sadn) address_mask_reg_q <= hwdata[7:0];
         if (w_rxdv) rxdiv_q <= hwdata[15:0];
         if (w_txdv) txdiv_q <= hwdata[15:0];
         if (w_imk) imk_q <= hwdata[IRQ_W-1:0];
      end
   end
   // ***************************************************************
   // Receiver
   // ***************************************************************
   logic       rx_m_q, rx_s_q;
   ufa_rx_st_t st_q;
   logic [3:0] ros_q;
   logic [15:0] rcnt_q;
   logic [2:0] bitn_q;
   logic [7:0] rsh_q;
   logic       ninth_q;
   logic       rtick, smp, ev_d8, ev_nin, ev_stop, done, bit9, accept;
   logic       match, rx_load, fe_set;
   logic [7:0] rx_byte;
   assign rtick = (st_q != RX_IDLE) & (rcnt_q == rxdiv_q);
   assign smp   = rtick & (ros_q == OS_MID);
   assign ev_d8 = smp & (st_q == RX_DATA) & (bitn_q == LAST_BIT);
   assign ev_nin  = smp & (st_q == RX_NINTH);
   assign ev_stop = smp & (st_q == RX_STOP);
   assign rx_byte = (st_q == RX_DATA) ? {rx_s_q, rsh_q[7:1]} : rsh_q;
   // Done follows the stop bit in mode 1 or when checking, else the ninth bit (the last data bit in mode 0).
   assign done = (mode == MODE0) ? ev_d8 :
                 (mode == MODE1) ? ev_stop :
                 (chk ? ev_stop : ev_nin);
   assign bit9 = ((st_q == RX_NINTH) | (mode == MODE1)) ? rx_s_q
                                                         : ninth_q;
   assign accept = ~mp_on | (bit9 & match);
   // A frame that finds the done flag still set is dropped.
   assign rx_load = done & accept & ~ri_q;
   assign fe_set  = ev_stop & chk & ~rx_s_q;
   ufa_addr_match u_match (
      .rx_byte   (rx_byte),
      .own_addr  (own_address_reg_q),
      .addr_mask (address_mask_reg_q),
      .match     (match)
   );
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_m_q <= 1'b1;
         rx_s_q <= 1'b1;
      end else begin
         rx_m_q <= rxd;
         rx_s_q <= rx_m_q;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= RX_IDLE;
         ros_q <= '0;
         rcnt_q <= '0;
         bitn_q <= '0;
         rsh_q <= '0;
         ninth_q <= 1'b0;
      end else begin
         rcnt_q <= (rtick | (st_q == RX_IDLE)) ? 16'h0000
                                               : rcnt_q + 16'h0001;
         if (st_q == RX_IDLE) ros_q <= '0;
         else if (rtick) ros_q <= ros_q + 4'h1;
         if (ev_nin) ninth_q <= rx_s_q;
         unique case (st_q)
            RX_IDLE: if (ctl_q.ren & ~rx_s_q) st_q <= RX_START;
            RX_START: if (smp) begin
               st_q <= rx_s_q ? RX_IDLE : RX_DATA;
               bitn_q <= '0;
            end
            RX_DATA: if (smp) begin
               rsh_q <= rx_byte;
               bitn_q <= bitn_q + 3'h1;
               if (bitn_q == LAST_BIT)
                  st_q <= mode[1] ? RX_NINTH : RX_STOP;
            end
            RX_NINTH: if (smp) st_q <= RX_STOP;
            RX_STOP: if (smp) st_q <= RX_IDLE;
         endcase
      end
   end
   // ***************************************************************
   // Transmitter, on its own divider so rates may differ
   // ***************************************************************
   logic [10:0] tsh_q;
   logic [3:0]  tleft_q, tos_q;
   logic [15:0] tcnt_q;
   logic        tbusy_q, txd_q, ttick, tedge, tx_go, tx_end;
   assign ttick  = tbusy_q & (tcnt_q == txdiv_q);
   assign tedge  = ttick & (tos_q == OS_LAST);
   assign tx_go  = w_sbuf & ~tbusy_q;
   assign tx_end = tedge & (tleft_q == 4'h1);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tsh_q <= '1;
         tleft_q <= '0;
         tos_q <= '0;
         tcnt_q <= '0;
         tbusy_q <= 1'b0;
         txd_q <= 1'b1;
      end else begin
         tcnt_q <= (ttick | tx_go) ? 16'h0000 : tcnt_q + 16'h0001;
         txd_q <= tbusy_q ? tsh_q[0] : 1'b1;
         if (tx_go) begin
            tsh_q <= {1'b1, mode[1] ? ctl_q.tb8 : 1'b1,
                      hwdata[7:0], 1'b0};
            tleft_q <= mode[1] ? TX_BITS9 : TX_BITS8;
            tos_q <= '0;
            tbusy_q <= 1'b1;
         end else if (ttick) begin
            tos_q <= tos_q + 4'h1;
            if (tedge) begin
               tsh_q <= {1'b1, tsh_q[10:1]};
               tleft_q <= tleft_q - 4'h1;
               if (tx_end) tbusy_q <= 1'b0;
            end
         end
      end
   end
   // ***************************************************************
   // Flags and interrupt; hardware set wins over software clear
   // ***************************************************************
   logic [IRQ_W-1:0] iev;
   logic             irq_q;
   assign iev = {fe_set, tx_end, rx_load};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fe_q <= 1'b0;
         ri_q <= 1'b0;
         ti_q <= 1'b0;
         rb8_q <= 1'b0;
         rbuf_q <= '0;
         ist_q <= '0;
         irq_q <= 1'b0;
      end else begin
         fe_q <= fe_set | ((w_serial_control_reg & fce_q) ? hwdata[SC_FE] : fe_q);
         ri_q <= rx_load | (w_serial_control_reg ? hwdata[SC_RI] : ri_q);
         ti_q <= tx_end | (w_serial_control_reg ? hwdata[SC_TI] : ti_q);
         if (rx_load) begin
            rbuf_q <= rx_byte;
            rb8_q <= bit9;
         end else if (w_serial_control_reg) begin
            rb8_q <= hwdata[SC_RB8];
         end
         ist_q <= iev | (ist_q & ~(w_ist ? hwdata[IRQ_W-1:0] : '0));
         irq_q <= |((iev | ist_q) & imk_q);
      end
   end
   // ***************************************************************
   // Read data
   // ***************************************************************
   logic [7:0]  serial_control_reg_rd;
   logic [31:0] rmux;
   assign serial_control_reg_rd = {fce_q ? fe_q : ctl_q.sm0,
                     ctl_q.sm1, ctl_q.sm2, ctl_q.ren, ctl_q.tb8,
                     rb8_q, ti_q, ri_q};
   always_comb begin
      rmux = 32'h0000_0000;
      unique case (ap_q.ofs)
         OFS_SERIAL_CONTROL_REG:   rmux[7:0] = serial_control_reg_rd;
         OFS_POWER_CONTROL_REG:   rmux[PC_FCE] = fce_q;
         OFS_OWN_ADDRESS_REG:  rmux[7:0] = own_address_reg_q;
         OFS_ADDRESS_MASK_REG:  rmux[7:0] = address_mask_reg_q;
         OFS_SBUF:   rmux[7:0] = rbuf_q;
         OFS_RXDIV:  rmux[15:0] = rxdiv_q;
         OFS_TXDIV:  rmux[15:0] = txdiv_q;
         OFS_IRQST:  rmux[IRQ_W-1:0] = ist_q;
         OFS_IRQMSK: rmux[IRQ_W-1:0] = imk_q;
         default:    rmux = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) rdata_q <= '0;
      else if (rd_q) rdata_q <= rmux;
   end
   assign hreadyout = rdy_q;
   assign hrdata    = rdata_q;
   assign hresp     = 1'b0;
   assign txd       = txd_q;
   assign irq       = irq_q;
   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_fe_mode;
      $rose(fe_q) |-> $past(fce_q) && ($past(mode) != MODE0);
   endproperty
   a_fe_mode: assert property (p_fe_mode)
      else $error("frame error set outside enabled async mode");
   property p_fe_set;
      ev_stop && chk && !rx_s_q |=> fe_q ##1 fe_q;
   endproperty
   a_fe_set: assert property (p_fe_set)
      else $error("bad stop bit did not set frame error");
   property p_fe_hold;
      fe_q && !(w_serial_control_reg && fce_q && !hwdata[SC_FE]) |=> fe_q;
   endproperty
   a_fe_hold: assert property (p_fe_hold)
      else $error("frame error cleared without software");
   property p_ri_at_stop;
      $rose(ri_q) && $past(chk) |-> $past(st_q) == RX_STOP;
   endproperty
   a_ri_at_stop: assert property (p_ri_at_stop)
      else $error("done not at stop bit with check on");
   property p_no_match;
      done && mp_on && !match && !ri_q && !w_serial_control_reg |=> !ri_q;
   endproperty
   a_no_match: assert property (p_no_match)
      else $error("non-matching address raised done");
   property p_m1_stop;
      $rose(ri_q) && $past(mp_on) && $past(mode) == MODE1
         |-> $past(rx_s_q) && $past(ev_stop);
   endproperty
   a_m1_stop: assert property (p_m1_stop)
      else $error("mode 1 address frame without valid stop");
   property p_m0_any;
      done && mode == MODE0 && !ri_q |=> ri_q;
   endproperty
   a_m0_any: assert property (p_m0_any)
      else $error("mode 0 frame filtered");
   property p_exact;
      address_mask_reg_q == 8'hff && rx_byte == own_address_reg_q |-> match;
   endproperty
   a_exact: assert property (p_exact)
      else $error("exact address not matched");
   property p_bcast;
      rx_byte == (own_address_reg_q | address_mask_reg_q) |-> match;
   endproperty
   a_bcast: assert property (p_bcast)
      else $error("broadcast address not matched");
   property p_rst_any;
      own_address_reg_q == ADDR_RST && address_mask_reg_q == MASK_RST |-> match;
   endproperty
   a_rst_any: assert property (p_rst_any)
      else $error("cleared address registers reject a byte");
   property p_duplex;
      tx_go && st_q != RX_IDLE && !smp |=> tbusy_q && st_q != RX_IDLE;
   endproperty
   a_duplex: assert property (p_duplex)
      else $error("transmit start disturbed reception");
   property p_bit7;
      w_serial_control_reg && !fce_q |=> fe_q == $past(fe_q);
   endproperty
   a_bit7: assert property (p_bit7)
      else $error("bit 7 write reached error flag while disabled");
   property p_ninth;
      $rose(ri_q) && $past(mp_on) && $past(mode[1]) |-> $past(bit9);
   endproperty
   a_ninth: assert property (p_ninth)
      else $error("data frame accepted in multiprocessor mode");
   c_fe:    cover property ($rose(fe_q));
   c_addr:  cover property (mp_on && rx_load);
   c_drop:  cover property (mp_on && done && !accept);
   c_duplx: cover property (tbusy_q && rx_load);
endmodule

// ==== rtl/ufa_pkg.sv ====
// Shared constants and types of the receive enhancements serial port.
// Assumes a single clock domain and an AHB-Lite register slave.
package ufa_pkg;
   // ***************************************************************
   // Register offsets (byte addresses, one word each)
   // ***************************************************************
   localparam logic [7:0] OFS_SERIAL_CONTROL_REG   = 8'h00;
   localparam logic [7:0] OFS_POWER_CONTROL_REG   = 8'h04;
   localparam logic [7:0] OFS_OWN_ADDRESS_REG  = 8'h08;
   localparam logic [7:0] OFS_ADDRESS_MASK_REG  = 8'h0c;
   localparam logic [7:0] OFS_SBUF   = 8'h10;
   localparam logic [7:0] OFS_RXDIV  = 8'h14;
   localparam logic [7:0] OFS_TXDIV  = 8'h18;
   localparam logic [7:0] OFS_IRQST  = 8'h1c;
   localparam logic [7:0] OFS_IRQMSK = 8'h20;
   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int SC_FE  = 7;
   localparam int SC_SM1 = 6;
   localparam int SC_SM2 = 5;
   localparam int SC_REN = 4;
   localparam int SC_TB8 = 3;
   localparam int SC_RB8 = 2;
   localparam int SC_TI  = 1;
   localparam int SC_RI  = 0;
   localparam int PC_FCE = 6;
   localparam int IRQ_RX = 0;
   localparam int IRQ_TX = 1;
   localparam int IRQ_FE = 2;
   localparam int IRQ_W  = 3;
   // ***************************************************************
   // Reset values and timing counts
   // ***************************************************************
   localparam logic [7:0]  ADDR_RST  = 8'h00;
   localparam logic [7:0]  MASK_RST  = 8'h00;
   localparam logic [15:0] DIV_RST   = 16'h006c;
   localparam logic [3:0]  OS_MID    = 4'h7;
   localparam logic [3:0]  OS_LAST   = 4'hf;
   localparam logic [2:0]  LAST_BIT  = 3'h7;
   localparam logic [3:0]  TX_BITS8  = 4'ha;
   localparam logic [3:0]  TX_BITS9  = 4'hb;
   localparam logic [1:0]  MODE0     = 2'h0;
   localparam logic [1:0]  MODE1     = 2'h1;
   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [2:0] {
      RX_IDLE  = 3'b000,
      RX_START = 3'b001,
      RX_DATA  = 3'b011,
      RX_NINTH = 3'b010,
      RX_STOP  = 3'b110
   } ufa_rx_st_t;
   typedef struct packed {
      logic sm0;
      logic sm1;
      logic sm2;
      logic ren;
      logic tb8;
   } ufa_ctl_t;
   typedef struct packed {
      logic       wr;
      logic [7:0] ofs;
   } ufa_aphase_t;
endpackage

// ==== rtl/ufa_addr_match.sv ====
// Address comparator for multiprocessor address frames.
// Assumes own address and mask come from registers; purely combinational.
module ufa_addr_match
   import ufa_pkg::*;
(
   input  wire logic [7:0] rx_byte,
   input  wire logic [7:0] own_addr,
   input  wire logic [7:0] addr_mask,
   output logic            match
);
   // Zero mask bits are don't-care in the given address.
   logic [7:0] bcast;
   logic       given_hit;
   logic       bcast_hit;
   assign given_hit = ((rx_byte ^ own_addr) & addr_mask) == 8'h00;
   assign bcast     = own_addr | addr_mask;
   assign bcast_hit = ((rx_byte ^ bcast) & bcast) == 8'h00;
   assign match     = given_hit | bcast_hit;
endmodule

// ==== dv/ufa_rmt_model.sv ====
// Behavioural remote transmitter that drives the serial line of the port.
// Assumes the bench calls send_frame and that one bit lasts BIT_CYC clocks.
module ufa_rmt_model
#(
   parameter int BIT_CYC = 64
)(
   input  wire logic hclk,
   output logic      rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***************************************************************
   // Frame generator
   // ***************************************************************
   initial rxd = 1'b1;
   // A bad stop bit stays low only past the sample point; the receiver
   // then sees at most a false start, which it drops at mid start bit.
   task automatic send_frame(input logic [7:0] data, input logic nine,
                             input logic use9, input logic stop);
      logic [10:0] fr;
      int          n;
      int          h;
      fr = {stop, nine, data, 1'b0};
      n = use9 ? 11 : 10;
      if (!use9) fr[9] = stop;
      for (int i = 0; i < n; i++) begin
         h = (i == n - 1 && !stop) ? BIT_CYC * 5 / 8 : BIT_CYC;
         @(posedge hclk);
         rxd <= fr[i];
         repeat (h - 1) @(posedge hclk);
      end
      @(posedge hclk);
      rxd <= 1'b1;
      repeat (BIT_CYC) @(posedge hclk);
   endtask
endmodule

// ==== dv/tb_uart_frame_error_addr_match.sv ====
// Self-checking bench of the serial port receive enhancements.
// Assumes one AHB-Lite master here and the remote model on rxd.
module tb_uart_frame_error_addr_match
   import ufa_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   logic        rxd;
   logic        txd;
   logic        irq;
   logic [31:0] rv;
   int          fail_count = 0;
   int          samples_checked = 0;

   ufa_top #(.DIV_DEFAULT(16'h0003)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .rxd(rxd), .txd(txd), .irq(irq));
   ufa_rmt_model #(.BIT_CYC(64)) u_rmt (.hclk(hclk), .rxd(rxd));

   // ***************************************************************
   // Bus and compare tasks
   // ***************************************************************
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h000000, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      xfer(1'b1, a, d, dummy);
   endtask
   task automatic rdchk(input string what, input logic [7:0] a,
                        input logic [31:0] msk, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0, rv);
      check(what, exp, rv & msk);
      check("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic frame(input logic [7:0] d, input logic nine,
                        input logic use9, input logic stop);
      u_rmt.send_frame(d, nine, use9, stop);
      repeat (4) @(posedge hclk);
   endtask

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic t_reset();
      rdchk("own_address_reg", OFS_OWN_ADDRESS_REG, 32'hff, 32'h0);
      rdchk("address_mask_reg", OFS_ADDRESS_MASK_REG, 32'hff, 32'h0);
      wr(8'h24, 32'hff);
      rdchk("unmapped", 8'h24, 32'hffffffff, 32'h0);
      wr(OFS_SERIAL_CONTROL_REG, 32'hf0);
      frame(8'h33, 1'b1, 1'b1, 1'b1);
      rdchk("any address", OFS_SERIAL_CONTROL_REG, 32'h5, 32'h5);
      rdchk("rx byte", OFS_SBUF, 32'hff, 32'h33);
   endtask
   // Each entry holds mask, address, ninth bit and expected done flag.
   task automatic t_addr();
      logic [23:0] tbl [9];
      logic [31:0] e;
      tbl = '{24'hfc5711, 24'hfc5411, 24'hfc5a10, 24'hfcfe11, 24'hfcff11,
              24'hfcf010, 24'hfc5600, 24'hff5710, 24'hff5611};
      wr(OFS_OWN_ADDRESS_REG, 32'h56);
      for (int i = 0; i < 9; i++) begin
         e = {31'h0, tbl[i][0]};
         wr(OFS_ADDRESS_MASK_REG, {24'h0, tbl[i][23:16]});
         wr(OFS_SERIAL_CONTROL_REG, i[0] ? 32'hb0 : 32'hf0);
         frame(tbl[i][15:8], tbl[i][4], 1'b1, 1'b1);
         rdchk("match", OFS_SERIAL_CONTROL_REG, 32'h1, e);
      end
   endtask
   task automatic t_mode();
      wr(OFS_SERIAL_CONTROL_REG, 32'h70);
      frame(8'h56, 1'b0, 1'b0, 1'b1);
      rdchk("mode1 good stop", OFS_SERIAL_CONTROL_REG, 32'h1, 32'h1);
      wr(OFS_SERIAL_CONTROL_REG, 32'h70);
      frame(8'h56, 1'b0, 1'b0, 1'b0);
      rdchk("mode1 bad stop", OFS_SERIAL_CONTROL_REG, 32'h1, 32'h0);
      wr(OFS_SERIAL_CONTROL_REG, 32'h30);
      frame(8'h5a, 1'b0, 1'b0, 1'b1);
      rdchk("mode0 no filter", OFS_SERIAL_CONTROL_REG, 32'h1, 32'h1);
   endtask
   task automatic t_fe();
      wr(OFS_SERIAL_CONTROL_REG, 32'h50);
      frame(8'ha5, 1'b0, 1'b0, 1'b0);
      rdchk("check off", OFS_SERIAL_CONTROL_REG, 32'h81, 32'h01);
      wr(OFS_POWER_CONTROL_REG, 32'h40);
      rdchk("no error", OFS_SERIAL_CONTROL_REG, 32'h80, 32'h0);
      wr(OFS_SERIAL_CONTROL_REG, 32'h50);
      frame(8'ha5, 1'b0, 1'b0, 1'b0);
      rdchk("frame error", OFS_SERIAL_CONTROL_REG, 32'h81, 32'h81);
      wr(OFS_SERIAL_CONTROL_REG, 32'hd0);
      frame(8'h3c, 1'b0, 1'b0, 1'b1);
      rdchk("error sticky", OFS_SERIAL_CONTROL_REG, 32'h81, 32'h81);
      wr(OFS_POWER_CONTROL_REG, 32'h0);
      rdchk("bit7 as mode", OFS_SERIAL_CONTROL_REG, 32'h80, 32'h0);
      wr(OFS_POWER_CONTROL_REG, 32'h40);
      rdchk("error kept", OFS_SERIAL_CONTROL_REG, 32'h80, 32'h80);
      wr(OFS_SERIAL_CONTROL_REG, 32'h50);
      rdchk("error cleared", OFS_SERIAL_CONTROL_REG, 32'h80, 32'h0);
   endtask
   // The done flag should come at the ninth bit without the check and
   // at the stop bit with it; the bit boundary lies 640 clocks in.
   task automatic t_timing();
      int n [2];
      wr(OFS_POWER_CONTROL_REG, 32'h0);
      wr(OFS_SERIAL_CONTROL_REG, 32'hd0);
      wr(OFS_IRQMSK, 32'h1);
      for (int f = 0; f < 2; f++) begin
         wr(OFS_IRQST, 32'h7);
         repeat (2) @(posedge hclk);
         n[f] = 0;
         fork
            u_rmt.send_frame(8'h81, 1'b1, 1'b1, 1'b1);
            while (irq !== 1'b1 && n[f] < 2000) begin
               @(posedge hclk);
               n[f]++;
            end
         join
         wr(OFS_POWER_CONTROL_REG, 32'h40);
         wr(OFS_SERIAL_CONTROL_REG, 32'h50);
      end
      check("done at ninth", 32'h1, {31'h0, n[0] < 640});
      check("done at stop", 32'h1, {31'h0, n[1] >= 640});
      check("irq raised", 32'h1, {31'h0, irq});
      wr(OFS_IRQMSK, 32'h0);
      repeat (2) @(posedge hclk);
      check("irq masked", 32'h0, {31'h0, irq});
      wr(OFS_IRQMSK, 32'h1);
      wr(OFS_IRQST, 32'h1);
      repeat (2) @(posedge hclk);
      check("irq cleared", 32'h0, {31'h0, irq});
   endtask
   // The transmitter runs twice as fast as the receiver here, and it
   // starts in mid-frame so that both directions overlap.
   task automatic t_duplex();
      logic [7:0] b;
      logic       s;
      wr(OFS_POWER_CONTROL_REG, 32'h0);
      wr(OFS_TXDIV, 32'h1);
      wr(OFS_SERIAL_CONTROL_REG, 32'h50);
      fork
         frame(8'h3c, 1'b0, 1'b0, 1'b1);
         begin
            repeat (300) @(posedge hclk);
            wr(OFS_SBUF, 32'ha5);
            while (txd !== 1'b0) @(posedge hclk);
            repeat (16) @(posedge hclk);
            for (int i = 0; i < 8; i++) begin
               repeat (32) @(posedge hclk);
               b[i] = txd;
            end
            repeat (32) @(posedge hclk);
            s = txd;
         end
      join
      check("tx byte", 32'ha5, {24'h0, b});
      check("tx stop", 32'h1, {31'h0, s});
      rdchk("rx byte", OFS_SBUF, 32'hff, 32'h3c);
      rdchk("rx and tx done", OFS_SERIAL_CONTROL_REG, 32'h3, 32'h3);
   endtask

   // ***************************************************************
   // Run control
   // ***************************************************************
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   initial begin
      repeat (80000) @(posedge hclk);
      fail_count++;
      $display("CHECK FAILED watchdog expected finish seen timeout");
      give_verdict();
   end
   initial begin
      hresetn = 1'b0;
      hsel    = 1'b0;
      haddr   = 32'h0;
      htrans  = 2'h0;
      hwrite  = 1'b0;
      hsize   = 3'h2;
      hwdata  = 32'h0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_addr();
      t_mode();
      t_fe();
      t_timing();
      t_duplex();
      give_verdict();
   end
endmodule
